// *** hw/cyclic_data_mapping_builder.sv ***
// builds the cyclic word layout from the input and output mapping slots
`timescale 1ns/1ps
module cyclic_data_mapping_builder (
  input  wire logic                      i_clk,
  input  wire logic                      i_nrst,
  input  wire logic                      i_reg_ctrl,
  input  wire logic [1:0]                i_nc_mode,
  input  wire logic [5:0]                i_len_in,
  input  wire logic [5:0]                i_len_out,
  input  wire logic [1:0]                i_own_slot,
  input  wire logic [3:0]                i_other_regctrl,
  input  wire logic [1:0]                i_lowest_app_slot,
  input  wire logic [31:0]               i_wide_menus,
  input  wire logic [15:0]               i_in_map [cdm_pkg::NSLOT],
  input  wire logic [15:0]               i_out_map [cdm_pkg::NSLOT],
  input  wire logic                      i_word_ready,
  output logic                           o_word_valid,
  output logic [cdm_pkg::WORD_W-1:0]     o_word_data,
  output logic [7:0]                     o_status,
  output logic [7:0]                     o_err_info,
  output logic                           o_map_err,
  output logic                           o_rw_mismatch,
  output logic                           o_over_len,
  output logic                           o_cyclic_run
);
  cdm_pkg::init_state_t st_ff;
  logic [15:0] map_ff [cdm_pkg::NENT];
  logic [4:0]  chk_ff;
  logic        seen1_ff;
  logic        seen4_ff;
  logic        in_err_ff;
  logic        out_err_ff;
  logic        grp_ff;
  logic [3:0]  idx_ff;
  logic [1:0]  sub_ff;
  logic        act_ff;
  logic [7:0]  par_ff;
  logic [4:0]  cur_idx;
  logic [15:0] ent;
  logic [15:0] nxt_ent;
  logic [9:0]  dec;
  logic [9:0]  dec_n;
  logic [5:0]  len_sel;
  logic [3:0]  lim;
  logic        grp_end;
  logic        is_nc;
  logic        rng;
  logic        wide;
  logic [1:0]  last_sub;
  logic [7:0]  cur_par;
  logic        emit;
  logic        fifo_rdy;
  logic [cdm_pkg::WORD_W-1:0] word;
  logic [15:0] chk_ent;
  logic        bad_su;
  logic        dup;
  logic        chk_last;
  logic [15:0] nc_ent;

  function automatic logic inr(input logic [7:0] v, input logic [7:0] lo,
                               input logic [7:0] hi);
    return (v >= lo) && (v <= hi);
  endfunction

  // slot-qualified menus fold onto base menus; slotless plc menus get the lowest application slot, others slot 0
  function automatic logic [9:0] decode(input logic [7:0] m, input logic [1:0] low);
    if (inr(m, cdm_pkg::S1_LO, cdm_pkg::S1_HI))
      return {2'h1, m - (cdm_pkg::S1_LO - cdm_pkg::PLC_LO)};
    if (inr(m, cdm_pkg::S2_LO, cdm_pkg::S2_HI))
      return {2'h2, m - (cdm_pkg::S2_LO - cdm_pkg::PLC_LO)};
    if (inr(m, cdm_pkg::S3_LO, cdm_pkg::S3_HI))
      return {2'h3, m - (cdm_pkg::S3_LO - cdm_pkg::PLC_LO)};
    if (inr(m, cdm_pkg::PLC_LO, cdm_pkg::PLC_HI))
      return {low, m};
    return {2'h0, m};
  endfunction

  // setup menu access check
  function automatic logic setup_bad(input logic [15:0] e, input logic [1:0] own,
                                     input logic [3:0] orc);
    logic [1:0] s;
    s = 2'(e[15:8] - cdm_pkg::SETUP_LO + 8'h01);
    if (e[15:8] == cdm_pkg::VSETUP) return 1'b1;
    if (!inr(e[15:8], cdm_pkg::SETUP_LO, cdm_pkg::SETUP_HI)) return 1'b0;
    if (s == own) return 1'b1;
    return inr(e[7:0], cdm_pkg::REG_I_BASE, cdm_pkg::REG_O_LAST) && !orc[s];
  endfunction

  // checking pass decode
  assign chk_ent  = map_ff[chk_ff];
  assign chk_last = chk_ff == 5'(cdm_pkg::NENT - 1);
  assign bad_su   = setup_bad(chk_ent, i_own_slot, i_other_regctrl);
  assign dup      = (chk_ent[15:8] == cdm_pkg::NC_MENU) &&
                    ((chk_ent[7:0] == cdm_pkg::NC_ONE_P) ? seen1_ff : seen4_ff);
  assign nc_ent   = {cdm_pkg::NC_MENU,
                     (i_nc_mode == cdm_pkg::NC_ONE) ? cdm_pkg::NC_ONE_P : cdm_pkg::NC_FOUR_P};

  // expansion pass decode
  assign cur_idx  = grp_ff ? 5'(idx_ff) + 5'(cdm_pkg::NSLOT) : 5'(idx_ff);
  assign ent      = map_ff[cur_idx];
  assign nxt_ent  = (idx_ff < 4'(cdm_pkg::NSLOT - 1)) ? map_ff[cur_idx + 5'h01] : 16'h0000;
  assign dec      = decode(ent[15:8], i_lowest_app_slot);
  assign dec_n    = decode(nxt_ent[15:8], i_lowest_app_slot);
  assign len_sel  = grp_ff ? i_len_out : i_len_in;
  assign lim      = (len_sel > 6'(cdm_pkg::NSLOT)) ? 4'(cdm_pkg::NSLOT) : len_sel[3:0];
  assign grp_end  = i_reg_ctrl ? (idx_ff >= lim) : (idx_ff >= 4'(cdm_pkg::NSLOT));
  assign is_nc    = ent[15:8] == cdm_pkg::NC_MENU;
  assign rng      = !i_reg_ctrl && !is_nc && (nxt_ent != 16'h0000) && (dec == dec_n) &&
                    (inr(dec[7:0], cdm_pkg::PLC_LO, cdm_pkg::PLC_RNG_HI) ||
                     inr(dec[7:0], cdm_pkg::DAPP_LO, cdm_pkg::DAPP_HI)) &&
                    (ent[7:0] < nxt_ent[7:0]);
  assign wide     = inr(dec[7:0], cdm_pkg::PLC_LO, cdm_pkg::PLC_HI) ||
                    ((dec[7:5] == 3'h0) && i_wide_menus[dec[4:0]]);
  assign last_sub = i_reg_ctrl ? 2'h0 :
                    is_nc ? ((ent[7:0] == cdm_pkg::NC_ONE_P) ? 2'h0 : 2'h3) :
                    wide ? 2'h1 : 2'h0;
  assign cur_par  = act_ff ? par_ff : ent[7:0];
  assign emit     = (st_ff == cdm_pkg::ST_EXPAND) && !grp_end &&
                    (i_reg_ctrl || ent != 16'h0000);
  assign word     = i_reg_ctrl ?
                    {grp_ff, i_own_slot, cdm_pkg::SETUP_LO + 8'(i_own_slot) - 8'h01,
                     (grp_ff ? cdm_pkg::REG_O_BASE : cdm_pkg::REG_I_BASE) + 8'(idx_ff),
                     2'h0} :
                    {grp_ff, dec, cur_par, sub_ff};

  // initialisation sequence, runs once after reset
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_ff <= cdm_pkg::ST_IDLE;
    end else begin
      unique case (st_ff)
        cdm_pkg::ST_IDLE:  st_ff <= cdm_pkg::ST_LOAD;
        cdm_pkg::ST_LOAD:  st_ff <= cdm_pkg::ST_FIX;
        cdm_pkg::ST_FIX:   st_ff <= cdm_pkg::ST_CHECK;
        cdm_pkg::ST_CHECK: begin
          if (i_reg_ctrl) begin
            st_ff <= cdm_pkg::ST_EXPAND;
          end else if (chk_last) begin
            st_ff <= (in_err_ff || out_err_ff || bad_su || dup) ?
                     cdm_pkg::ST_FAIL : cdm_pkg::ST_EXPAND;
          end
        end
        cdm_pkg::ST_EXPAND: begin
          if (grp_ff && grp_end) st_ff <= cdm_pkg::ST_RUN;
        end
        cdm_pkg::ST_RUN:   st_ff <= cdm_pkg::ST_RUN;
        cdm_pkg::ST_FAIL:  st_ff <= cdm_pkg::ST_FAIL;
      endcase
    end
  end

  // slot capture and non-cyclic channel insertion or removal
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int k = 0; k < cdm_pkg::NENT; k++) map_ff[k] <= 16'h0000;
    end else if (st_ff == cdm_pkg::ST_LOAD) begin
      for (int k = 0; k < cdm_pkg::NSLOT; k++) begin
        map_ff[k]                 <= i_in_map[k];
        map_ff[k + cdm_pkg::NSLOT] <= i_out_map[k];
      end
    end else if (st_ff == cdm_pkg::ST_FIX) begin
      // only the first slot of each group is examined
      for (int g = 0; g < cdm_pkg::NENT; g += cdm_pkg::NSLOT) begin
        if (i_nc_mode != cdm_pkg::NC_NONE) begin
          if (map_ff[g][15:8] != cdm_pkg::NC_MENU) begin
            for (int k = 1; k < cdm_pkg::NSLOT; k++) map_ff[g + k] <= map_ff[g + k - 1];
          end
          map_ff[g] <= nc_ent;
        end else if (i_reg_ctrl && map_ff[g][15:8] == cdm_pkg::NC_MENU) begin
          for (int k = 0; k < cdm_pkg::NSLOT - 1; k++) begin
            map_ff[g + k] <= map_ff[g + k + 1];
          end
          map_ff[g + cdm_pkg::NSLOT - 1] <= 16'h0000;
        end
      end
    end
  end

  // validation pass over all twenty slots
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      chk_ff        <= 5'h00;
      seen1_ff      <= 1'b0;
      seen4_ff      <= 1'b0;
      in_err_ff     <= 1'b0;
      out_err_ff    <= 1'b0;
      o_map_err     <= 1'b0;
      o_rw_mismatch <= 1'b0;
      o_err_info    <= 8'h00;
    end else if (st_ff == cdm_pkg::ST_CHECK && !i_reg_ctrl && !chk_last) begin
      chk_ff <= chk_ff + 5'h01;
      // duplicate tracking restarts with the output group
      if (chk_ff == 5'(cdm_pkg::NSLOT - 1)) begin
        seen1_ff <= 1'b0;
        seen4_ff <= 1'b0;
      end else if (chk_ent[15:8] == cdm_pkg::NC_MENU) begin
        if (chk_ent[7:0] == cdm_pkg::NC_ONE_P) seen1_ff <= 1'b1;
        else seen4_ff <= 1'b1;
      end
      if (bad_su) o_rw_mismatch <= 1'b1;
      if (bad_su || dup) begin
        o_map_err <= 1'b1;
        if (chk_ff >= 5'(cdm_pkg::NSLOT)) out_err_ff <= 1'b1;
        else in_err_ff <= 1'b1;
        if (!o_map_err) o_err_info <= {bad_su, dup, 1'b0, chk_ff};
      end
    end else if (st_ff == cdm_pkg::ST_CHECK && !i_reg_ctrl) begin
      // last slot always belongs to the output group
      if (bad_su) o_rw_mismatch <= 1'b1;
      if (bad_su || dup) begin
        o_map_err  <= 1'b1;
        out_err_ff <= 1'b1;
        if (!o_map_err) o_err_info <= {bad_su, dup, 1'b0, chk_ff};
      end
    end
  end

  // word expansion walker, stalls on fifo back-pressure
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      grp_ff <= 1'b0;
      idx_ff <= 4'h0;
      sub_ff <= 2'h0;
      act_ff <= 1'b0;
      par_ff <= 8'h00;
    end else if (st_ff != cdm_pkg::ST_EXPAND) begin
      grp_ff <= 1'b0;
      idx_ff <= 4'h0;
      sub_ff <= 2'h0;
      act_ff <= 1'b0;
    end else if (grp_end) begin
      grp_ff <= 1'b1;
      idx_ff <= 4'h0;
    end else if (!emit) begin
      idx_ff <= idx_ff + 4'h1;
    end else if (fifo_rdy) begin
      if (sub_ff != last_sub) begin
        sub_ff <= sub_ff + 2'h1;
      end else begin
        sub_ff <= 2'h0;
        if (rng && cur_par < nxt_ent[7:0]) begin
          par_ff <= cur_par + 8'h01;
          act_ff <= 1'b1;
        end else begin
          act_ff <= 1'b0;
          idx_ff <= idx_ff + (rng ? 4'h2 : 4'h1);
        end
      end
    end
  end

  // status, over-length and run indication
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_status     <= cdm_pkg::STAT_BUSY;
      o_over_len   <= 1'b0;
      o_cyclic_run <= 1'b0;
    end else begin
      if (st_ff == cdm_pkg::ST_LOAD)
        o_over_len <= i_reg_ctrl && ((i_len_in > 6'(cdm_pkg::NSLOT)) ||
                                     (i_len_out > 6'(cdm_pkg::NSLOT)));
      if (st_ff == cdm_pkg::ST_FAIL)
        o_status <= out_err_ff ? cdm_pkg::STAT_OERR : cdm_pkg::STAT_IERR;
      else if (st_ff == cdm_pkg::ST_RUN)
        o_status <= cdm_pkg::STAT_OK;
      o_cyclic_run <= st_ff == cdm_pkg::ST_RUN;
    end
  end

  // layout words toward the fieldbus side
  word_fifo #(
    .WIDTH (cdm_pkg::WORD_W),
    .DEPTH (cdm_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_clk   (i_clk),
    .i_nrst  (i_nrst),
    .i_valid (emit),
    .i_data  (word),
    .o_ready (fifo_rdy),
    .o_valid (o_word_valid),
    .o_data  (o_word_data),
    .i_ready (i_word_ready)
  );
endmodule // cyclic_data_mapping_builder

// *** inc/cdm_pkg.sv ***
// constants and types shared by the cyclic data mapping builder
package cdm_pkg;
  localparam int        NSLOT      = 10;
  localparam int        NENT       = 20;
  localparam int        WORD_W     = 21;
  localparam int        FIFO_DEPTH = 4;
  // menu identifiers
  localparam logic [7:0] SETUP_LO   = 8'h0f;
  localparam logic [7:0] SETUP_HI   = 8'h11;
  localparam logic [7:0] VSETUP     = 8'h3c;
  localparam logic [7:0] DAPP_LO    = 8'h12;
  localparam logic [7:0] DAPP_HI    = 8'h14;
  localparam logic [7:0] PLC_LO     = 8'h46;
  localparam logic [7:0] PLC_RNG_HI = 8'h4b;
  localparam logic [7:0] PLC_HI     = 8'h5b;
  localparam logic [7:0] S1_LO      = 8'h64;
  localparam logic [7:0] S1_HI      = 8'h7f;
  localparam logic [7:0] S2_LO      = 8'h82;
  localparam logic [7:0] S2_HI      = 8'h9d;
  localparam logic [7:0] S3_LO      = 8'ha0;
  localparam logic [7:0] S3_HI      = 8'hbb;
  // register-control data registers inside a setup menu
  localparam logic [7:0] REG_I_BASE = 8'h0a;
  localparam logic [7:0] REG_O_BASE = 8'h14;
  localparam logic [7:0] REG_O_LAST = 8'h1d;
  // non-cyclic virtual entry
  localparam logic [7:0] NC_MENU    = 8'h3d;
  localparam logic [7:0] NC_ONE_P   = 8'h01;
  localparam logic [7:0] NC_FOUR_P  = 8'h04;
  localparam logic [1:0] NC_NONE    = 2'h0;
  localparam logic [1:0] NC_ONE     = 2'h1;
  // status codes
  localparam logic [7:0] STAT_BUSY  = 8'hff;
  localparam logic [7:0] STAT_IERR  = 8'hfe;
  localparam logic [7:0] STAT_OERR  = 8'hfd;
  localparam logic [7:0] STAT_OK    = 8'h00;
  typedef enum logic [2:0] {
    ST_IDLE, ST_LOAD, ST_FIX, ST_CHECK, ST_EXPAND, ST_RUN, ST_FAIL
  } init_state_t;
endpackage

// *** hw/word_fifo.sv ***
// small fifo with a registered output stage
`timescale 1ns/1ps
module word_fifo #(
  parameter int WIDTH = 21,
  parameter int DEPTH = 4
) (
  input  wire logic             i_clk,
  input  wire logic             i_nrst,
  input  wire logic             i_valid,
  input  wire logic [WIDTH-1:0] i_data,
  output logic                  o_ready,
  output logic                  o_valid,
  output logic      [WIDTH-1:0] o_data,
  input  wire logic             i_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ff;
  logic [AW-1:0]    rd_ff;
  logic [AW:0]      cnt_ff;
  logic             push;
  logic             pop;

  // full is honest: no write while all entries hold data
  assign o_ready = cnt_ff < (AW+1)'(DEPTH);
  assign push    = i_valid && o_ready;
  assign pop     = (cnt_ff != '0) && (!o_valid || i_ready);

  // storage
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_ff[wr_ff] <= i_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) wr_ff <= wr_ff + 1'b1;
      if (pop) rd_ff <= rd_ff + 1'b1;
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // output stage
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_valid <= 1'b0;
      o_data  <= '0;
    end else if (pop) begin
      o_valid <= 1'b1;
      o_data  <= mem_ff[rd_ff];
    end else if (i_ready) begin
      o_valid <= 1'b0;
    end
  end
endmodule // word_fifo

// *** dv/cdm_master_model.sv ***
// fieldbus master model taking layout words, promptly or slowly
`timescale 1ns/1ps
module cdm_master_model (
  input  wire logic i_clk,
  input  wire logic i_nrst,
  input  wire logic i_slow,
  output logic      o_ready
);
  logic [1:0] phase_ff;
  // free phase counter, changes only after an edge
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      phase_ff <= 2'h0;
    end else begin
      phase_ff <= phase_ff + 2'h1;
    end
  end
  // slow mode takes one word in four so the fifo fills and refuses
  assign o_ready = !i_slow || (phase_ff == 2'h3);
endmodule // cdm_master_model

// *** dv/cyclic_data_mapping_builder_asserts.sv ***
// assertions on status, flags and word handshake of the mapping builder
`timescale 1ns/1ps
module cyclic_data_mapping_builder_asserts (
  input wire logic                      i_clk,
  input wire logic                      i_nrst,
  input wire logic                      i_reg_ctrl,
  input wire logic [5:0]                i_len_in,
  input wire logic [5:0]                i_len_out,
  input wire logic [1:0]                i_own_slot,
  input wire logic                      i_word_ready,
  input wire logic                      o_word_valid,
  input wire logic [cdm_pkg::WORD_W-1:0] o_word_data,
  input wire logic [7:0]                o_status,
  input wire logic                      o_map_err,
  input wire logic                      o_rw_mismatch,
  input wire logic                      o_over_len,
  input wire logic                      o_cyclic_run
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  logic [7:0] menu;
  logic [7:0] param;
  // fields of the offered word
  assign menu  = o_word_data[17:10];
  assign param = o_word_data[9:2];
  AST_RUN_OK: assert property (o_cyclic_run |-> o_status == cdm_pkg::STAT_OK)
    else $error("run without ok status");
  AST_FAIL_SILENT: assert property (o_map_err |-> !o_cyclic_run && !o_word_valid)
    else $error("activity after mapping error");
  AST_OUT_ERR: assert property (o_status == cdm_pkg::STAT_OERR |-> o_map_err)
    else $error("output error status without error flag");
  AST_RW_FLAG: assert property (o_rw_mismatch |-> o_map_err && !o_cyclic_run)
    else $error("mismatch flag without mapping error");
  AST_HOLD_WORD: assert property (o_word_valid && !i_word_ready |=>
    o_word_valid && $stable(o_word_data))
    else $error("offered word changed before taken");
  AST_OVER_LEN: assert property ($rose(o_cyclic_run) |-> o_over_len ==
    (i_reg_ctrl && (i_len_in > 6'h0a || i_len_out > 6'h0a)))
    else $error("over-length flag wrong");
  AST_REG_MENU: assert property (o_word_valid && i_reg_ctrl |->
    menu == cdm_pkg::SETUP_LO + {6'h00, i_own_slot} - 8'h01 && o_word_data[1:0] == 2'h0)
    else $error("register control word not in own setup menu");
  AST_REG_LIMIT: assert property (o_word_valid && i_reg_ctrl |->
    param < (o_word_data[20] ? 8'h1e : 8'h14))
    else $error("register control word beyond ten");
  AST_NO_VSETUP: assert property (o_word_valid && !i_reg_ctrl |->
    menu != cdm_pkg::VSETUP)
    else $error("virtual setup menu word emitted");
  COV_RUN: cover property ($rose(o_cyclic_run) && i_reg_ctrl);
  COV_ERR: cover property ($rose(o_rw_mismatch));
  COV_STALL: cover property (o_word_valid && !i_word_ready ##1 i_word_ready);
endmodule // cyclic_data_mapping_builder_asserts

// *** dv/cyclic_data_mapping_builder_tb_top.sv ***
// self-checking bench for the cyclic data mapping builder
`timescale 1ns/1ps
module cyclic_data_mapping_builder_tb_top;
  logic                       i_clk    = 1'b0;
  logic                       i_nrst   = 1'b0;
  logic                       reg_ctrl = 1'b0;
  logic [1:0]                 nc_mode  = 2'h0;
  logic [5:0]                 len_in   = 6'h00;
  logic [5:0]                 len_out  = 6'h00;
  logic [1:0]                 own_slot = 2'h1;
  logic [3:0]                 oth      = 4'h4;
  logic [1:0]                 low_slot = 2'h2;
  logic                       slow     = 1'b0;
  logic [15:0]                in_map  [cdm_pkg::NSLOT];
  logic [15:0]                out_map [cdm_pkg::NSLOT];
  logic                       ready;
  logic                       valid;
  logic [cdm_pkg::WORD_W-1:0] data;
  logic [7:0]                 status;
  logic [7:0]                 err_info;
  logic                       map_err;
  logic                       rw;
  logic                       over_len;
  logic                       run;
  logic [20:0]                got [$];
  logic [20:0]                exp_q [$];
  logic [20:0]                msk_q [$];
  int                         fails = 0;
  int                         n_checks = 0;
  always #12.5 i_clk = ~i_clk;
  cyclic_data_mapping_builder u_dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_reg_ctrl(reg_ctrl),
    .i_nc_mode(nc_mode), .i_len_in(len_in), .i_len_out(len_out), .i_own_slot(own_slot),
    .i_other_regctrl(oth), .i_lowest_app_slot(low_slot), .i_wide_menus(32'h0000_0004),
    .i_in_map(in_map), .i_out_map(out_map), .i_word_ready(ready), .o_word_valid(valid),
    .o_word_data(data), .o_status(status), .o_err_info(err_info), .o_map_err(map_err),
    .o_rw_mismatch(rw), .o_over_len(over_len), .o_cyclic_run(run));
  cdm_master_model u_master (.i_clk(i_clk), .i_nrst(i_nrst), .i_slow(slow), .o_ready(ready));
  // record every word the master takes
  always @(posedge i_clk) begin
    if (i_nrst && valid && ready) got.push_back(data);
  end
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e, input logic [31:0] m);
    n_checks++;
    if ((g & m) !== (e & m)) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // add n expected words of one entry; slot compared only when cs is set
  task automatic ex(input logic d, input logic [1:0] s, input logic cs, input logic [7:0] m,
                    input logic [7:0] p, input int n);
    for (int i = 0; i < n; i++) begin
      exp_q.push_back({d, s, m, p, i[1:0]});
      msk_q.push_back({1'b1, {2{cs}}, 18'h3ffff});
    end
  endtask
  // enter reset and restore the default configuration
  task automatic hold_rst;
    @(negedge i_clk);
    i_nrst = 1'b0;
    for (int i = 0; i < cdm_pkg::NSLOT; i++) begin
      in_map[i] = 16'h0000;
      out_map[i] = 16'h0000;
    end
    exp_q.delete();
    msk_q.delete();
    {reg_ctrl, nc_mode, len_in, len_out, own_slot} = {1'b0, 2'h0, 12'h0, 2'h1};
    {oth, slow, low_slot} = {4'h4, 1'b0, 2'h2};
  endtask
  // release reset and wait for a final status
  task automatic go;
    int k;
    repeat (2) @(negedge i_clk);
    cmp(status, 8'hff, 32'hff);
    got.delete();
    i_nrst = 1'b1;
    for (k = 0; k < 600 && status === 8'hff; k++) @(negedge i_clk);
    if (k == 600) begin
      fails++;
      wrap_up();
    end
    repeat (30) @(negedge i_clk);
  endtask
  task automatic chk_words;
    cmp(got.size(), exp_q.size(), 32'hffffffff);
    for (int i = 0; i < exp_q.size() && i < got.size(); i++) begin
      cmp(got[i], exp_q[i], msk_q[i]);
    end
  endtask
  // mapped layout with ranges, slot decode, widths and a stalling master
  task automatic t_map;
    hold_rst();
    slow = 1'b1;
    in_map = '{16'h0a28, 16'h0201, 16'h820b, 16'h820f, 16'h4703, 16'h100b,
               16'h0000, 16'h0000, 16'h0000, 16'h0000};
    out_map = '{16'h3d01, 16'h062a, 16'h1205, 16'h1203, 16'ha001, 16'ha002,
                16'h0000, 16'h0000, 16'h0000, 16'h0000};
    ex(0, 2'h0, 0, 8'h0a, 8'h28, 1);
    ex(0, 2'h0, 0, 8'h02, 8'h01, 2);
    for (int p = 11; p <= 15; p++) ex(0, 2'h2, 1, 8'h46, p[7:0], 2);
    ex(0, 2'h2, 1, 8'h47, 8'h03, 2);
    ex(0, 2'h0, 0, 8'h10, 8'h0b, 1);
    ex(1, 2'h0, 0, 8'h3d, 8'h01, 1);
    ex(1, 2'h0, 0, 8'h06, 8'h2a, 1);
    ex(1, 2'h0, 0, 8'h12, 8'h05, 1);
    ex(1, 2'h0, 0, 8'h12, 8'h03, 1);
    ex(1, 2'h3, 1, 8'h46, 8'h01, 2);
    ex(1, 2'h3, 1, 8'h46, 8'h02, 2);
    go();
    chk_words();
    cmp(status, cdm_pkg::STAT_OK, 32'hff);
    cmp(run, 1'b1, 32'h1);
    cmp(over_len, 1'b0, 32'h1);
    $display("test mapped layout done");
  endtask
  // register control in slot two with an over-long input length
  task automatic t_regctrl;
    hold_rst();
    {reg_ctrl, own_slot, len_in, len_out} = {1'b1, 2'h2, 6'h0c, 6'h03};
    for (int k = 0; k < 10; k++) ex(0, 2'h2, 1, 8'h10, 8'h0a + k[7:0], 1);
    for (int k = 0; k < 3; k++) ex(1, 2'h2, 1, 8'h10, 8'h14 + k[7:0], 1);
    go();
    chk_words();
    cmp(over_len, 1'b1, 32'h1);
    cmp(run, 1'b1, 32'h1);
    $display("test register control done");
  endtask
  // non-cyclic insertion, rewrite and an entry pushed out of the last slot
  task automatic t_nc;
    hold_rst();
    nc_mode = cdm_pkg::NC_ONE;
    in_map[0] = 16'h0a28;
    in_map[1] = 16'h3d04;
    in_map[2] = 16'h4801;
    in_map[9] = 16'h0201;
    out_map[0] = 16'h3d04;
    out_map[1] = 16'h062a;
    low_slot = 2'h3;
    ex(0, 2'h0, 0, 8'h3d, 8'h01, 1);
    ex(0, 2'h0, 0, 8'h0a, 8'h28, 1);
    ex(0, 2'h0, 0, 8'h3d, 8'h04, 4);
    ex(0, 2'h3, 1, 8'h48, 8'h01, 2);
    ex(1, 2'h0, 0, 8'h3d, 8'h01, 1);
    ex(1, 2'h0, 0, 8'h06, 8'h2a, 1);
    go();
    chk_words();
    $display("test non-cyclic done");
  endtask
  // four-word channel: rewrite, insertion and a one-word channel beside it
  task automatic t_nc4;
    hold_rst();
    nc_mode = 2'h2;
    in_map[0] = 16'h062a;
    in_map[1] = 16'h3d01;
    out_map[0] = 16'h3d01;
    ex(0, 2'h0, 0, 8'h3d, 8'h04, 4);
    ex(0, 2'h0, 0, 8'h06, 8'h2a, 1);
    ex(0, 2'h0, 0, 8'h3d, 8'h01, 1);
    ex(1, 2'h0, 0, 8'h3d, 8'h04, 4);
    go();
    chk_words();
    cmp(status, cdm_pkg::STAT_OK, 32'hff);
    $display("test four-word channel done");
  endtask
  // one refused mapping: no words, fail status and flags
  task automatic t_err(input logic [1:0] nc, input logic out, input int idx,
                       input logic [15:0] ent, input logic [7:0] st, input logic rwe,
                       input logic [7:0] inf, input logic [7:0] im);
    hold_rst();
    nc_mode = nc;
    oth = 4'h0;
    if (out) out_map[idx] = ent;
    else in_map[idx] = ent;
    go();
    cmp(got.size(), 0, 32'hffffffff);
    cmp(status, st, 32'hff);
    cmp(map_err, 1'b1, 32'h1);
    cmp(rw, rwe, 32'h1);
    cmp(err_info, inf, im);
    cmp(run, 1'b0, 32'h1);
    $display("test refused mapping done");
  endtask
  initial begin
    hold_rst();
    t_map();
    t_regctrl();
    t_nc();
    t_nc4();
    t_err(2'h1, 1, 3, 16'h3d01, cdm_pkg::STAT_OERR, 0, 8'h40, 8'h40);
    t_err(2'h0, 0, 0, 16'h0f0a, cdm_pkg::STAT_IERR, 1, 8'h80, 8'hff);
    t_err(2'h0, 0, 0, 16'h3c0a, cdm_pkg::STAT_IERR, 1, 8'h80, 8'hff);
    t_err(2'h0, 0, 0, 16'h100b, cdm_pkg::STAT_IERR, 1, 8'h80, 8'hff);
    wrap_up();
  end
endmodule // cyclic_data_mapping_builder_tb_top
bind cyclic_data_mapping_builder cyclic_data_mapping_builder_asserts u_chk (
  .i_clk(i_clk), .i_nrst(i_nrst), .i_reg_ctrl(i_reg_ctrl), .i_len_in(i_len_in),
  .i_len_out(i_len_out), .i_own_slot(i_own_slot), .i_word_ready(i_word_ready),
  .o_word_valid(o_word_valid), .o_word_data(o_word_data), .o_status(o_status),
  .o_map_err(o_map_err), .o_rw_mismatch(o_rw_mismatch), .o_over_len(o_over_len),
  .o_cyclic_run(o_cyclic_run));
